// file: include/adc_port_params.svh
// Constants for the pipelined converter output port.
// Included by the package and the design; defines only.
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH
`define WORD_BITS        14
`define PIPE_HALF_STEPS  16
`define CONV_STAGES      10
`define SETTLE_TIME_MS   10
`define PCLK_FREQ_KHZ    10000
`define REG_CTRL         12'h000
`define REG_IRQ_STATUS   12'h004
`define REG_IRQ_MASK     12'h008
`define REG_STATE        12'h00C
`define CTRL_FMT_BIT     0
`define IRQ_SETTLED_BIT  0
`define IRQ_OVER_BIT     1
`define IRQ_PDOWN_BIT    2
`define IRQ_BITS         3
`define CTRL_RESET       1'b0
`define MASK_RESET       3'h0
`define PERIOD_BITS      8
`define MSB_FLIP         14'h2000
`endif

// file: include/adc_port_pkg.sv
// Types shared by the converter output port.
// Assumes adc_port_params.svh is on the include path.
`include "adc_port_params.svh"
package adc_port_pkg;
  // One converted sample with its over-range mark
  typedef struct packed {
    logic                    ovr;
    logic [`WORD_BITS-1:0]   code;
  } sample_s;
endpackage

// file: design/adc_output_port.sv
// Digital side of a 14-bit pipelined converter: sampling, pipeline,
// output coding, strobe generation, power-down and an APB register file.
// Assumes the conversion clock and analog code arrive asynchronous to pclk.
// Assumes the package is compiled first; format select is a register bit.
//
// Function
// - Result appears eight conversion cycles after sampling.
// - Sample advances one stage every half cycle.
// - Track while clock high, hold while low.
// - Power-down pin high idles the device.
// - Reference settles 10 ms after release, power-up.
// - Two's complement when format low, Gray high.
// - Strobe copies clock with duty correction.
// - Bus bit zero carries the LSB.
// - Bus bit thirteen carries the MSB.
// - Over-range flag marks out-of-scale input, aligned.
// - Outputs change on falling strobe edge.
// - Input sampled on conversion clock falling edge.
`include "adc_port_params.svh"
module adc_output_port #(
  parameter int SETTLE_CYCLES = `SETTLE_TIME_MS * `PCLK_FREQ_KHZ
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  conversion_clock_pos,
  input  wire logic [`WORD_BITS-1:0] analog_code,
  input  wire logic                  analog_over,
  input  wire logic                  power_down_pin,
  output logic      [`WORD_BITS-1:0] sample_word,
  output logic      [`WORD_BITS-1:0] sample_word_oe_n,
  output logic                       over_range_flag,
  output logic                       over_range_flag_oe_n,
  output logic                       data_valid_strobe,
  output logic                       data_valid_strobe_oe_n,
  output logic                       irq
);
  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  typedef adc_port_pkg::sample_s sample_t;

  // two's or Gray
  // Output coding: Gray is taken over offset binary; the MSB flip turns
  // two's complement into offset binary first
  function automatic sample_t encode(input sample_t s, input logic gray);
    logic [`WORD_BITS-1:0] ob;
    encode = s;
    ob = s.code ^ `MSB_FLIP;
    if (gray) begin
      encode.code = ob ^ (ob >> 1);
    end
  endfunction

  // Two-flop synchronisers for all pins from outside pclk
  // The third flop only feeds edge detection; nothing but the second
  // stage reads the first, so a metastable value never reaches logic.
  // The analog word is not Gray coded: it is only taken while the
  // conversion clock is high, long after the word last changed.
  logic                  clk_s1_q, clk_s2_q, clk_s3_q;
  logic                  pd_s1_q, pd_s2_q, pd_s3_q;
  sample_t               ain_s1_q, ain_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {clk_s1_q, clk_s2_q, clk_s3_q} <= 3'h0;
      {pd_s1_q, pd_s2_q, pd_s3_q}    <= 3'h0;
      ain_s1_q <= '0;
      ain_s2_q <= '0;
    end else if (clk_en) begin
      clk_s1_q <= conversion_clock_pos;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      pd_s1_q  <= power_down_pin;
      pd_s2_q  <= pd_s1_q;
      pd_s3_q  <= pd_s2_q;
      ain_s1_q <= {analog_over, analog_code};
      ain_s2_q <= ain_s1_q;
    end
  end

  // Edge events of the sampled conversion clock and power-down pin
  // Both edges come from one flop pair, so rise and fall never fire
  // together and keep the pin's timing relation.
  wire fall_evt = clk_s3_q & ~clk_s2_q;
  wire rise_evt = ~clk_s3_q & clk_s2_q;
  wire edge_evt = fall_evt | rise_evt;
  wire pd_fell  = pd_s3_q & ~pd_s2_q;
  wire pd_rose  = ~pd_s3_q & pd_s2_q;

  // track and hold
  // The hold starts two pclk cycles after the pin falls, matching the
  // delay of the analog word through its own synchroniser.
  sample_t held_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= '0;
    end else if (clk_en && clk_s2_q) begin
      held_q <= ain_s2_q;
    end
  end

  // half-cycle shift, ten stages then output alignment
  // Ten stages plus six alignment steps make sixteen half steps, so a
  // word leaves exactly eight conversion periods after it entered.
  sample_t pipe_q [`PIPE_HALF_STEPS];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `PIPE_HALF_STEPS; i++) pipe_q[i] <= '0;
    end else if (clk_en && edge_evt) begin
      // entry only on the falling edge
      pipe_q[0] <= fall_evt ? held_q : pipe_q[0];
      for (int i = 1; i < `PIPE_HALF_STEPS; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end

  // Register file state
  logic                  fmt_q;
  logic [`IRQ_BITS-1:0]  irq_stat_q, irq_mask_q;
  logic [CW-1:0]         settle_cnt_q;
  logic                  settling_q;
  sample_t               out_q;
  wire sample_t          coded = encode(pipe_q[`PIPE_HALF_STEPS-1], fmt_q);

  // word loads on the eighth falling edge after sampling
  // bit zero stays the LSB, bit thirteen the MSB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else if (clk_en && fall_evt) begin
      out_q <= coded;
    end
  end

  // strobe rebuilt from measured period, fixed half-period high
  // The period is re-measured every cycle, so a new rate is followed
  // after one period; a stalled clock saturates the counter instead
  // of wrapping into a false strobe.
  logic [`PERIOD_BITS-1:0] per_cnt_q, half_q;
  logic                    strobe_q;
  wire                     cnt_full = &per_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= '0;
      half_q    <= '0;
      strobe_q  <= 1'b0;
    end else if (clk_en) begin
      per_cnt_q <= fall_evt ? '0 : per_cnt_q + {{(`PERIOD_BITS-1){1'b0}}, ~cnt_full};
      if (fall_evt) begin
        half_q <= (per_cnt_q + 1'b1) >> 1;
      end
      // strobe falls with the word update
      if (fall_evt) begin
        strobe_q <= 1'b0;
      end else if (per_cnt_q + 1'b1 == half_q) begin
        strobe_q <= 1'b1;
      end
    end
  end

  // settle counter after reset and power-down release
  // Outputs are not gated while settling: the receiver discards those
  // words itself, from the state register or the settled interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_q <= '0;
      settling_q   <= 1'b1;
    end else if (clk_en) begin
      if (pd_s2_q || pd_fell) begin
        settle_cnt_q <= '0;
        settling_q   <= 1'b1;
      end else if (settling_q) begin
        settle_cnt_q <= settle_cnt_q + 1'b1;
        settling_q   <= (settle_cnt_q != CW'(SETTLE_CYCLES - 1));
      end
    end
  end

  // pins released while powered down; enables are active low
  logic oe_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_q <= 1'b1;
    end else if (clk_en) begin
      oe_n_q <= pd_s2_q;
    end
  end

  // APB decode; answers in the first access cycle
  wire acc      = psel & penable & pready;
  wire hit_ctrl = paddr == `REG_CTRL;
  wire hit_stat = paddr == `REG_IRQ_STATUS;
  wire hit_mask = paddr == `REG_IRQ_MASK;
  wire hit_st   = paddr == `REG_STATE;
  wire mapped   = hit_ctrl | hit_stat | hit_mask | hit_st;
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h0, fmt_q} :
    hit_stat ? {29'h0, irq_stat_q} :
    hit_mask ? {29'h0, irq_mask_q} :
    hit_st   ? {15'h0, out_q.ovr, out_q.code, pd_s2_q, settling_q} :
               32'h0000_0000;
  wire [`IRQ_BITS-1:0] ev = {pd_rose, fall_evt & coded.ovr,
                             settling_q & ~pd_s2_q & ~pd_fell &
                             (settle_cnt_q == CW'(SETTLE_CYCLES - 1))};
  wire rd_clr = acc & ~pwrite & hit_stat;
  // Only the bits handed out are cleared, so an event that lands after
  // the capture in the setup cycle survives the read.
  wire [`IRQ_BITS-1:0] stat_kept =
    rd_clr ? (irq_stat_q & ~prdata[`IRQ_BITS-1:0]) : irq_stat_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      fmt_q      <= `CTRL_RESET;
      irq_mask_q <= `MASK_RESET;
      irq_stat_q <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
      if (acc && pwrite && hit_ctrl) begin
        fmt_q <= pwdata[`CTRL_FMT_BIT];
      end
      if (acc && pwrite && hit_mask) begin
        irq_mask_q <= pwdata[`IRQ_BITS-1:0];
      end
      // New events win over the read clear
      irq_stat_q <= stat_kept | ev;
      irq        <= |((stat_kept | ev) & irq_mask_q);
    end
  end

  // Pins straight from flops; released pins keep their value inside and
  // only the enables move, so the receiver sees its pull levels.
  assign sample_word            = out_q.code;
  assign over_range_flag        = out_q.ovr;
  assign data_valid_strobe      = strobe_q;
  assign sample_word_oe_n       = {`WORD_BITS{oe_n_q}};
  assign over_range_flag_oe_n   = oe_n_q;
  assign data_valid_strobe_oe_n = oe_n_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  latency_load_a: assert property (clk_en && fall_evt |=>
    out_q == $past(coded)) else $error("word not loaded at fall");
  pipe_shift_a: assert property (clk_en && edge_evt |=>
    pipe_q[1] == $past(pipe_q[0])) else $error("pipe did not advance");
  track_hold_a: assert property (clk_en && !clk_s2_q |=>
    $stable(held_q)) else $error("held value moved while low");
  pd_release_a: assert property (clk_en && pd_s2_q |=>
    oe_n_q ##1 (!clk_en || oe_n_q || !pd_s2_q))
    else $error("pins driven in power-down");
  settle_start_a: assert property (clk_en && pd_fell |=>
    settling_q [*2]) else $error("settling not restarted");
  gray_fmt_a: assert property (clk_en && fall_evt && fmt_q |=>
    out_q.code[`WORD_BITS-1] == ~$past(pipe_q[`PIPE_HALF_STEPS-1].code[
    `WORD_BITS-1])) else $error("Gray msb wrong");
  twos_fmt_a: assert property (clk_en && fall_evt && !fmt_q |=>
    out_q.code[0] == $past(pipe_q[`PIPE_HALF_STEPS-1].code[0]))
    else $error("lsb misplaced");
  strobe_fall_a: assert property ($changed(out_q) |->
    $fell(strobe_q) || $past(strobe_q) == 1'b0) else $error("word moved");
  strobe_rise_a: assert property (clk_en && !fall_evt &&
    per_cnt_q + 1'b1 == half_q |=> strobe_q) else $error("strobe late");
  over_align_a: assert property (clk_en && fall_evt |=>
    out_q.ovr == $past(pipe_q[`PIPE_HALF_STEPS-1].ovr))
    else $error("flag misaligned");
  sample_edge_a: assert property (clk_en && fall_evt |=>
    pipe_q[0] == $past(held_q)) else $error("sample not on fall");

  // track, shift and hold of the datapath
  held_track_a: assert property (clk_en && clk_s2_q |=>
    held_q == $past(ain_s2_q)) else $error("held value not tracking");
  pipe_tail_a: assert property (clk_en && edge_evt |=>
    pipe_q[`PIPE_HALF_STEPS-1] == $past(pipe_q[`PIPE_HALF_STEPS-2]))
    else $error("pipe tail did not advance");
  pipe_hold_a: assert property (clk_en && !edge_evt |=>
    $stable(pipe_q[0])) else $error("pipe moved without edge");
  out_hold_a: assert property (clk_en && !fall_evt |=>
    $stable(out_q)) else $error("word moved off the fall");

  // power-down drives enables and restarts settling
  pd_drive_a: assert property (clk_en && !pd_s2_q |=>
    !oe_n_q) else $error("pins not driven in normal mode");
  settle_hold_a: assert property (clk_en && pd_s2_q |=>
    settling_q && settle_cnt_q == '0)
    else $error("settling ran in power-down");
  settle_end_a: assert property (clk_en && !pd_s2_q && !pd_fell &&
    settling_q && settle_cnt_q == CW'(SETTLE_CYCLES - 1) |=>
    !settling_q) else $error("settling did not end");

  // strobe shape against the measured period
  strobe_low_a: assert property (clk_en && fall_evt |=>
    !strobe_q) else $error("strobe high at word change");
  strobe_idle_a: assert property (clk_en && !fall_evt && !strobe_q &&
    per_cnt_q + 1'b1 != half_q |=> !strobe_q)
    else $error("strobe rose early");
  per_sat_a: assert property (clk_en && cnt_full && !fall_evt |=>
    cnt_full) else $error("period counter wrapped");

  // Clock enable low freezes the datapath
  freeze_a: assert property (!clk_en |=>
    $stable(out_q) && $stable(strobe_q) && $stable(pipe_q[0]))
    else $error("state moved while frozen");

  // APB handshake: one ready pulse per transfer
  apb_ready_a: assert property (clk_en && psel && !penable |=>
    pready) else $error("no ready in access");
  apb_pulse_a: assert property (clk_en && pready && penable |=>
    !pready) else $error("ready held too long");
  apb_err_a: assert property (clk_en && psel && !penable && !mapped |=>
    pslverr && prdata == 32'h0000_0000) else $error("unmapped answered");
  ctrl_write_a: assert property (clk_en && acc && pwrite && hit_ctrl |=>
    fmt_q == $past(pwdata[`CTRL_FMT_BIT])) else $error("ctrl not written");
  mask_write_a: assert property (clk_en && acc && pwrite && hit_mask |=>
    irq_mask_q == $past(pwdata[`IRQ_BITS-1:0]))
    else $error("mask not written");

  // Interrupt status: events win, a read clears what it returned
  stat_set_a: assert property (clk_en && |ev |=>
    (irq_stat_q & $past(ev)) == $past(ev)) else $error("event lost");
  stat_clear_a: assert property (clk_en && rd_clr && !(|ev) |=>
    (irq_stat_q & $past(prdata[`IRQ_BITS-1:0])) == '0)
    else $error("status not cleared");
  irq_level_a: assert property (clk_en |=>
    irq == |(irq_stat_q & $past(irq_mask_q))) else $error("irq level wrong");
endmodule

// file: bench/adc_receiver_model.sv
// Back-end receiver: latches each word on the strobe rise.
// Assumes data lines pulled up and strobe pulled down when released.
module adc_receiver_model (
  input  wire logic        strobe,
  input  wire logic        strobe_oe_n,
  input  wire logic [13:0] word,
  input  wire logic [13:0] word_oe_n,
  input  wire logic        ovr,
  input  wire logic        ovr_oe_n,
  input  wire logic        discard,
  output adc_port_pkg::sample_s cap
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released lines read as their pull level, never the old value
  wire        stb_line = strobe_oe_n ? 1'b0 : strobe;
  wire [14:0] bus_line = {ovr_oe_n | ovr, word_oe_n | word};
  always @(posedge stb_line)
    if (!discard)
      cap <= bus_line;
endmodule

// file: bench/adc_output_port_test.sv
// Bench for the converter output port: APB, stream, power-down.
// Assumes the params header on the include path; pclk 100 ns.
`include "adc_port_params.svh"
module adc_output_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, clk_en, psel, penable, pwrite;
  logic        conv, pd, disc, over, pready, pslverr, irq, err;
  logic        stb, stb_oe_n, ovr, ovr_oe_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] code, word, word_oe_n;
  logic [7:0]  f;
  int          error_cnt, checks;
  adc_port_pkg::sample_s cap;
  adc_port_pkg::sample_s samp [256];

  adc_output_port #(.SETTLE_CYCLES(20)) u_adc_output_port (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conversion_clock_pos(conv), .analog_code(code), .analog_over(over),
    .power_down_pin(pd), .sample_word(word), .sample_word_oe_n(word_oe_n),
    .over_range_flag(ovr), .over_range_flag_oe_n(ovr_oe_n),
    .data_valid_strobe(stb), .data_valid_strobe_oe_n(stb_oe_n), .irq(irq));
  adc_receiver_model u_adc_receiver_model (
    .strobe(stb), .strobe_oe_n(stb_oe_n), .word(word),
    .word_oe_n(word_oe_n), .ovr(ovr), .ovr_oe_n(ovr_oe_n),
    .discard(disc), .cap(cap));

  // Clocks; link phase offset keeps them unrelated
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    conv = 1'b0;
    #37;
    forever #400 conv = ~conv;
  end
  // New analog value at the first pclk edge of track, so it is settled at the fall
  always @(posedge conv) begin
    @(posedge pclk);
    code <= code + 14'h0a5b;
    over <= code[1] & code[0];
  end
  // Record what the falling edge sampled
  always @(negedge conv) begin
    samp[f] = {over, code};
    f = f + 8'd1;
  end

  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // APB master: held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Own coder: Gray works on offset binary
  function automatic adc_port_pkg::sample_s enc(
      adc_port_pkg::sample_s s, logic g);
    logic [13:0] b;
    b = s.code ^ 14'h2000;
    if (g)
      s.code = b ^ (b >> 1);
    return s;
  endfunction

  task automatic t_regs();
    apb(1'b0, `REG_CTRL, '0);
    chk(rd === 32'h0000_0000, "ctrl reset");
    apb(1'b0, `REG_IRQ_MASK, '0);
    chk(rd === 32'h0000_0000, "mask reset");
    apb(1'b0, 12'h010, '0);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_freeze();
    logic [13:0] w;
    logic        s;
    clk_en <= 1'b0;
    @(posedge pclk);
    w = word;
    s = stb;
    repeat (12) @(posedge pclk);
    chk(word === w && stb === s, "clock enable freeze");
    clk_en <= 1'b1;
    $display("test freeze done");
  endtask
  task automatic t_stream(input logic g);
    realtime t0;
    apb(1'b1, `REG_CTRL, {31'h0, g});
    apb(1'b0, `REG_CTRL, '0);
    chk(rd === {31'h0, g}, "ctrl rw");
    repeat (9) @(posedge stb);
    for (int i = 0; i < 10; i++) begin
      @(posedge stb);
      #1;
      chk(cap === enc(samp[f - 8'd9], g), "word");
      if (i > 0)
        chk($realtime - t0 == 800.0, "strobe period");
      t0 = $realtime;
    end
    $display("test stream done");
  endtask
  task automatic t_pdown();
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0004);
    apb(1'b0, `REG_IRQ_STATUS, '0);
    pd <= 1'b1;
    disc <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(&{word_oe_n, stb_oe_n, ovr_oe_n} === 1'b1, "released");
    chk(irq === 1'b1, "irq raised");
    apb(1'b0, `REG_IRQ_STATUS, '0);
    chk(rd[2:0] === 3'b100 || rd[2:0] === 3'b110, "pd status");
    @(posedge pclk);
    chk(irq === 1'b0, "irq cleared, over-range masked");
    pd <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(word_oe_n === 14'h0000, "driving");
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0001);
    apb(1'b0, `REG_STATE, '0);
    chk(rd[0] === 1'b1, "settling");
    repeat (30) @(posedge pclk);
    apb(1'b0, `REG_STATE, '0);
    chk(rd[0] === 1'b0 && irq === 1'b1, "settled");
    disc <= 1'b0;
    $display("test pdown done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well past the expected 40 us run
  initial begin
    #400_000;
    error_cnt++;
    $display("mismatch %0t timeout", $time);
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, pd, disc, over} = '0;
    {paddr, pwdata, code, f} = '0;
    clk_en = 1'b1;
    repeat (12) @(posedge pclk);
    chk(word_oe_n === 14'h3fff && irq === 1'b0, "reset");
    presetn <= 1'b1;
    t_regs();
    t_freeze();
    t_stream(1'b0);
    t_stream(1'b1);
    t_pdown();
    close_out();
  end
endmodule
